// >>> shared/tco_pkg.sv
// package: constants and types for the thread context operations block
package tco_pkg;
  // sizes
  localparam int NUM_CTX    = 4;
  localparam int NUM_VPROC  = 2;
  localparam int CTX_W      = 2;
  // apb register offsets (byte addresses)
  localparam logic [7:0] ADDR_MT_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_VP_CTRL0  = 8'h04;
  localparam logic [7:0] ADDR_VP_CTRL1  = 8'h08;
  localparam logic [7:0] ADDR_VP_CONFIG = 8'h0c;
  localparam logic [7:0] ADDR_FEATURES  = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_BIND      = 8'h40;
  localparam logic [7:0] ADDR_RESTART   = 8'h60;
  // field positions
  localparam int GLOBAL_EN_BIT   = 0;
  localparam int TARGET_LSB      = 0;
  localparam int THREADS_EN_BIT  = 15;
  localparam int CAUSE_LSB       = 16;
  localparam int FEAT_MT_BIT     = 0;
  localparam int FEAT_TP_BIT     = 1;
  localparam int FEAT_CP0_BIT    = 2;
  localparam int BIND_HALT_BIT   = 8;
  localparam int ST_CU_LSB       = 28;
  localparam int ST_MX_BIT       = 27;
  localparam int ST_ONE_HI_BIT   = 20;
  localparam int ST_DA_BIT       = 15;
  localparam int ST_ACT_BIT      = 13;
  localparam int ST_KSU_LSB      = 11;
  localparam int ST_INTERRUPT_EXEMPT_BIT_BIT     = 10;
  // values
  localparam logic [2:0]  CAUSE_OVERFLOW = 3'h1;
  localparam logic [31:0] ALL_ONES       = 32'hffffffff;
  localparam logic [31:0] FEAT_RESET     = 32'h00000007;
  localparam logic [31:0] STATUS_RESET   = 32'h00000000;
  // register numbers reachable by the system register read
  localparam logic [7:0] SR_MT_CTRL  = 8'h01;
  localparam logic [7:0] SR_VP_CTRL  = 8'h09;
  localparam logic [7:0] SR_VP_CFG   = 8'h0a;
  localparam logic [7:0] SR_STATUS   = 8'h11;
  localparam logic [7:0] SR_BIND     = 8'h12;
  localparam logic [7:0] SR_RESTART  = 8'h13;
  localparam logic [7:0] SR_TPTR     = 8'h22;
  localparam logic [4:0] DSP_CTRL_SEL = 5'h10;
  typedef enum logic [1:0] {TCO_OP_ENABLE_ALL, TCO_OP_FORK, TCO_OP_MOVE_FROM} tco_op_e;
  typedef enum logic [1:0] {TCO_EXC_NONE, TCO_EXC_RESERVED, TCO_EXC_COP_UNUSABLE,
                            TCO_EXC_THREAD} tco_exc_e;
endpackage

// >>> src/tco_thread_ops.sv
// module: execution logic for vproc enable, thread allocate and context read
`timescale 1ns/100ps
`default_nettype none
module tco_thread_ops (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          ce_i,
  // apb slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [7:0]                    paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic                               pready_o,
  output logic [31:0]                        prdata_o,
  output logic                               pslverr_o,
  // instruction issue
  input  wire logic                          instr_valid_i,
  input  wire tco_pkg::tco_op_e              instr_op_i,
  input  wire logic [tco_pkg::CTX_W-1:0]     issue_ctx_i,
  input  wire logic [4:0]                    rd_i,
  input  wire logic [4:0]                    rt_i,
  input  wire logic                          u_i,
  input  wire logic [2:0]                    sel_i,
  input  wire logic                          h_i,
  input  wire logic [31:0]                   rs_val_i,
  input  wire logic [31:0]                   rt_val_i,
  // context state load
  input  wire logic                          st_we_i,
  input  wire logic [1:0]                    st_kind_i,
  input  wire logic [tco_pkg::CTX_W-1:0]     st_ctx_i,
  input  wire logic [4:0]                    st_idx_i,
  input  wire logic [63:0]                   st_data_i,
  // results
  output logic                               res_valid_o,
  output logic [31:0]                        res_data_o,
  output tco_pkg::tco_exc_e                  exc_code_o,
  output logic [tco_pkg::NUM_CTX-1:0]        ctx_run_o,
  output logic [tco_pkg::NUM_CTX-1:0]        ctx_addr_fault_o
);
  localparam int N = tco_pkg::NUM_CTX;

  // ==========================================================================
  // state
  logic                      global_en_q;
  logic [31:0]               vp_ctrl_q [tco_pkg::NUM_VPROC];
  logic [tco_pkg::NUM_VPROC-1:0] master_q;
  logic [31:0]               feat_q;
  logic [31:0]               status_q  [N];
  logic [N-1:0]              owner_q;
  logic [N-1:0]              halt_q;
  logic [31:0]               restart_q [N];
  logic [31:0]               tptr_q    [N];
  logic [31:0]               gpr_q     [N][32];
  logic [31:0]               acc_q     [N][16];
  logic [31:0]               dspc_q    [N];
  logic [63:0]               fpr_q     [N][32];
  logic [N-1:0]              fault_q;

  function automatic logic [31:0] sext8(input logic [31:0] v);
    return {{24{v[7]}}, v[7:0]};
  endfunction

  // status word of a freshly allocated context
  function automatic logic [31:0] new_status(input logic [31:0] prior,
                                             input logic [31:0] issuer);
    logic [31:0] s;
    s = '0;
    s[tco_pkg::ST_CU_LSB +: 4]      = prior[tco_pkg::ST_CU_LSB +: 4];
    s[tco_pkg::ST_MX_BIT]           = prior[tco_pkg::ST_MX_BIT];
    s[tco_pkg::ST_ONE_HI_BIT]       = 1'b1;
    s[tco_pkg::ST_DA_BIT + 1 +: 4]  = prior[tco_pkg::ST_DA_BIT + 1 +: 4];
    s[tco_pkg::ST_DA_BIT]           = 1'b1;
    s[tco_pkg::ST_ACT_BIT]          = 1'b1;
    s[tco_pkg::ST_KSU_LSB +: 2]     = issuer[tco_pkg::ST_KSU_LSB +: 2];
    s[tco_pkg::ST_INTERRUPT_EXEMPT_BIT_BIT]         = prior[tco_pkg::ST_INTERRUPT_EXEMPT_BIT_BIT];
    s[7:0]                          = issuer[7:0];
    return s;
  endfunction

  // lowest eligible index, with a found flag on top
  function automatic logic [tco_pkg::CTX_W:0] find_free(input logic [N-1:0] ok);
    logic [tco_pkg::CTX_W:0] r;
    r = '0;
    for (int t = N - 1; t >= 0; t--) begin
      if (ok[t]) begin
        r = {1'b1, tco_pkg::CTX_W'(t)};
      end
    end
    return r;
  endfunction

  // binding word: owner in bit 0, halt flag above
  function automatic logic [31:0] bind_word(input logic owner, input logic halt);
    return {23'h0, halt, 7'h0, owner};
  endfunction

  // start address that the new thread will fault on
  function automatic logic start_fault(input logic [31:0] a);
    return a[1] & ~a[0];
  endfunction

  // ==========================================================================
  // decode
  logic                      go;
  logic                      issuer_vp;
  logic                      issuer_master;
  logic                      mt_ok;
  logic                      en_go;
  logic                      fork_go;
  logic                      fork_fail;
  logic                      mf_go;
  logic                      fork_found;
  logic [tco_pkg::CTX_W-1:0] fork_pick;
  logic [N-1:0]              da_vec;
  logic [N-1:0]              act_vec;
  logic [N-1:0]              elig;
  logic [tco_pkg::CTX_W-1:0] tgt_ctx;
  logic                      tgt_vp;
  logic [31:0]               mt_ctrl_word;
  logic [31:0]               mf_data;
  logic [31:0]               res_d;
  tco_pkg::tco_exc_e         exc_d;
  logic                      apb_req;
  logic                      apb_wr;
  logic                      mt_wr;
  logic [tco_pkg::CTX_W-1:0] apb_idx;
  logic [31:0]               rd_word;
  logic                      rd_hit;
  logic                      pready_q;
  logic [31:0]               prdata_q;
  logic                      pslverr_q;
  logic                      res_valid_q;
  logic [31:0]               res_data_q;
  tco_pkg::tco_exc_e         exc_code_q;
  logic [N-1:0]              run_q;

  // one instruction taken per result pulse
  assign go            = ce_i & instr_valid_i & ~res_valid_q;
  assign issuer_vp     = owner_q[issue_ctx_i];
  assign issuer_master = master_q[issuer_vp];
  assign mt_ok         = feat_q[tco_pkg::FEAT_MT_BIT] & feat_q[tco_pkg::FEAT_CP0_BIT];
  assign en_go         = go & mt_ok & (instr_op_i == tco_pkg::TCO_OP_ENABLE_ALL);
  assign fork_go       = go & mt_ok & (instr_op_i == tco_pkg::TCO_OP_FORK) & fork_found;
  assign fork_fail     = go & mt_ok & (instr_op_i == tco_pkg::TCO_OP_FORK) & ~fork_found;
  assign mf_go         = go & mt_ok & (instr_op_i == tco_pkg::TCO_OP_MOVE_FROM);
  assign mt_ctrl_word  = {31'h0, global_en_q};
  assign tgt_ctx       = vp_ctrl_q[issuer_vp][tco_pkg::TARGET_LSB +: tco_pkg::CTX_W];
  assign tgt_vp        = owner_q[tgt_ctx];

  // ==========================================================================
  // allocate search
  always_comb begin
    for (int t = 0; t < N; t++) begin
      da_vec[t]  = status_q[t][tco_pkg::ST_DA_BIT];
      act_vec[t] = status_q[t][tco_pkg::ST_ACT_BIT];
      elig[t]    = (owner_q[t] == issuer_vp) & da_vec[t] & ~halt_q[t] & ~act_vec[t];
    end
  end

  // first hit only, so one context at most per allocate
  assign {fork_found, fork_pick} = find_free(elig);

  // ==========================================================================
  // context read
  always_comb begin
    mf_data = tco_pkg::ALL_ONES;
    if (!issuer_master && (tgt_vp != issuer_vp)) begin
      mf_data = tco_pkg::ALL_ONES;
    end else if (!u_i) begin
      case ({sel_i, rt_i})
        tco_pkg::SR_MT_CTRL: begin
          mf_data = mt_ctrl_word;
        end
        tco_pkg::SR_VP_CTRL: begin
          mf_data = vp_ctrl_q[tgt_vp];
        end
        tco_pkg::SR_VP_CFG: begin
          mf_data = {31'h0, master_q[tgt_vp]};
        end
        tco_pkg::SR_STATUS: begin
          mf_data = status_q[tgt_ctx];
        end
        tco_pkg::SR_BIND: begin
          mf_data = bind_word(owner_q[tgt_ctx], halt_q[tgt_ctx]);
        end
        tco_pkg::SR_RESTART: begin
          mf_data = restart_q[tgt_ctx];
        end
        tco_pkg::SR_TPTR: begin
          mf_data = feat_q[tco_pkg::FEAT_TP_BIT] ? tptr_q[tgt_ctx] : tco_pkg::ALL_ONES;
        end
        default: begin
          mf_data = tco_pkg::ALL_ONES;
        end
      endcase
    end else begin
      case (sel_i)
        3'h0: begin
          mf_data = gpr_q[tgt_ctx][rt_i];
        end
        3'h1: begin
          // usable bits of the target are not consulted
          if (rt_i == tco_pkg::DSP_CTRL_SEL) begin
            mf_data = dspc_q[tgt_ctx];
          end else if (rt_i < 5'h0f && rt_i[1:0] != 2'h3) begin
            if (rt_i[1:0] == 2'h2) begin
              mf_data = sext8(acc_q[tgt_ctx][rt_i[3:0]]);
            end else begin
              mf_data = acc_q[tgt_ctx][rt_i[3:0]];
            end
          end else begin
            mf_data = tco_pkg::ALL_ONES;
          end
        end
        3'h2: begin
          if (h_i) begin
            mf_data = fpr_q[tgt_ctx][rt_i][63:32];
          end else begin
            mf_data = fpr_q[tgt_ctx][rt_i][31:0];
          end
        end
        default: begin
          mf_data = tco_pkg::ALL_ONES;
        end
      endcase
    end
  end

  // ==========================================================================
  // result and exception
  always_comb begin
    exc_d = tco_pkg::TCO_EXC_NONE;
    if (!feat_q[tco_pkg::FEAT_MT_BIT]) begin
      exc_d = tco_pkg::TCO_EXC_RESERVED;
    end else if (!feat_q[tco_pkg::FEAT_CP0_BIT]) begin
      exc_d = tco_pkg::TCO_EXC_COP_UNUSABLE;
    end else if (instr_op_i == tco_pkg::TCO_OP_FORK && !fork_found) begin
      exc_d = tco_pkg::TCO_EXC_THREAD;
    end
  end

  always_comb begin
    res_d = '0;
    if (mt_ok) begin
      case (instr_op_i)
        tco_pkg::TCO_OP_ENABLE_ALL: begin
          res_d = mt_ctrl_word;
        end
        tco_pkg::TCO_OP_MOVE_FROM: begin
          res_d = mf_data;
        end
        default: begin
          res_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      res_valid_q <= 1'b0;
      res_data_q  <= '0;
      exc_code_q  <= tco_pkg::TCO_EXC_NONE;
    end else if (ce_i) begin
      res_valid_q <= go;
      if (go) begin
        res_data_q <= res_d;
        exc_code_q <= exc_d;
      end
    end
  end

  // ==========================================================================
  // register bus
  assign apb_req = psel_i & penable_i & ~pready_q;
  assign apb_wr  = ce_i & psel_i & penable_i & pready_q & pwrite_i;
  assign mt_wr   = apb_wr & (paddr_i == tco_pkg::ADDR_MT_CTRL);
  assign apb_idx = paddr_i[3:2];

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (paddr_i[7:4] == tco_pkg::ADDR_STATUS[7:4]) begin
      rd_word = status_q[apb_idx];
    end else if (paddr_i[7:4] == tco_pkg::ADDR_BIND[7:4]) begin
      rd_word = bind_word(owner_q[apb_idx], halt_q[apb_idx]);
    end else if (paddr_i[7:4] == tco_pkg::ADDR_RESTART[7:4]) begin
      rd_word = restart_q[apb_idx];
    end else begin
      case (paddr_i)
        tco_pkg::ADDR_MT_CTRL: begin
          rd_word = mt_ctrl_word;
        end
        tco_pkg::ADDR_VP_CTRL0: begin
          rd_word = vp_ctrl_q[0];
        end
        tco_pkg::ADDR_VP_CTRL1: begin
          rd_word = vp_ctrl_q[1];
        end
        tco_pkg::ADDR_VP_CONFIG: begin
          rd_word = {30'h0, master_q};
        end
        tco_pkg::ADDR_FEATURES: begin
          rd_word = feat_q;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
  end

  // one wait state: answer registered, then the access completes
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (ce_i) begin
      pready_q  <= apb_req;
      pslverr_q <= apb_req & ~rd_hit;
      if (apb_req) begin
        prdata_q <= rd_word;
      end
    end
  end

  // ==========================================================================
  // processor-wide enable
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      global_en_q <= 1'b0;
    end else if (ce_i) begin
      if (en_go && issuer_master) begin
        global_en_q <= 1'b1;
      end else if (mt_wr) begin
        global_en_q <= pwdata_i[tco_pkg::GLOBAL_EN_BIT];
      end
    end
  end

  // ==========================================================================
  // per-vproc control, hardware cause set wins over a write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (int v = 0; v < tco_pkg::NUM_VPROC; v++) begin
        vp_ctrl_q[v] <= '0;
      end
    end else if (ce_i) begin
      if (apb_wr && paddr_i == tco_pkg::ADDR_VP_CTRL0) begin
        vp_ctrl_q[0] <= pwdata_i;
      end
      if (apb_wr && paddr_i == tco_pkg::ADDR_VP_CTRL1) begin
        vp_ctrl_q[1] <= pwdata_i;
      end
      if (fork_fail) begin
        vp_ctrl_q[issuer_vp][tco_pkg::CAUSE_LSB +: 3] <= tco_pkg::CAUSE_OVERFLOW;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      master_q <= '0;
      feat_q   <= tco_pkg::FEAT_RESET;
    end else if (ce_i) begin
      if (apb_wr && paddr_i == tco_pkg::ADDR_VP_CONFIG) begin
        master_q <= pwdata_i[tco_pkg::NUM_VPROC-1:0];
      end
      if (apb_wr && paddr_i == tco_pkg::ADDR_FEATURES) begin
        feat_q <= pwdata_i;
      end
    end
  end

  // ==========================================================================
  // context control state
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (int t = 0; t < N; t++) begin
        status_q[t]  <= tco_pkg::STATUS_RESET;
        restart_q[t] <= '0;
      end
      owner_q <= '0;
      halt_q  <= '0;
      fault_q <= '0;
    end else if (ce_i) begin
      if (apb_wr && paddr_i[7:4] == tco_pkg::ADDR_STATUS[7:4]) begin
        status_q[apb_idx] <= pwdata_i;
      end
      if (apb_wr && paddr_i[7:4] == tco_pkg::ADDR_BIND[7:4]) begin
        owner_q[apb_idx] <= pwdata_i[0];
        halt_q[apb_idx]  <= pwdata_i[tco_pkg::BIND_HALT_BIT];
      end
      if (apb_wr && paddr_i[7:4] == tco_pkg::ADDR_RESTART[7:4]) begin
        restart_q[apb_idx] <= pwdata_i;
      end
      if (fork_go) begin
        status_q[fork_pick]  <= new_status(status_q[fork_pick], status_q[issue_ctx_i]);
        restart_q[fork_pick] <= rs_val_i;
        fault_q[fork_pick]   <= start_fault(rs_val_i);
      end
    end
  end

  // ==========================================================================
  // context data state
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (int t = 0; t < N; t++) begin
        tptr_q[t] <= '0;
        dspc_q[t] <= '0;
        for (int r = 0; r < 32; r++) begin
          gpr_q[t][r] <= '0;
          fpr_q[t][r] <= '0;
        end
        for (int r = 0; r < 16; r++) begin
          acc_q[t][r] <= '0;
        end
      end
    end else if (ce_i) begin
      if (st_we_i) begin
        case (st_kind_i)
          2'h0: begin
            gpr_q[st_ctx_i][st_idx_i] <= st_data_i[31:0];
          end
          2'h1: begin
            acc_q[st_ctx_i][st_idx_i[3:0]] <= st_data_i[31:0];
          end
          2'h2: begin
            if (st_idx_i[0]) begin
              tptr_q[st_ctx_i] <= st_data_i[31:0];
            end else begin
              dspc_q[st_ctx_i] <= st_data_i[31:0];
            end
          end
          default: begin
            fpr_q[st_ctx_i][st_idx_i] <= st_data_i;
          end
        endcase
      end
      if (fork_go) begin
        gpr_q[fork_pick][rd_i] <= rt_val_i;
        if (feat_q[tco_pkg::FEAT_TP_BIT]) begin
          tptr_q[fork_pick] <= tptr_q[issue_ctx_i];
        end
      end
    end
  end

  // ==========================================================================
  // run permission
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      run_q <= '0;
    end else if (ce_i) begin
      for (int t = 0; t < N; t++) begin
        run_q[t] <= act_vec[t] & ~halt_q[t] & global_en_q
                    & vp_ctrl_q[owner_q[t]][tco_pkg::THREADS_EN_BIT];
      end
    end
  end

  // ==========================================================================
  // outputs
  assign pready_o         = pready_q;
  assign prdata_o         = prdata_q;
  assign pslverr_o        = pslverr_q;
  assign res_valid_o      = res_valid_q;
  assign res_data_o       = res_data_q;
  assign exc_code_o       = exc_code_q;
  assign ctx_run_o        = run_q;
  assign ctx_addr_fault_o = fault_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_enable_sets: assert property (en_go && issuer_master |=> global_en_q)
    else $error("global enable not set by master");
  chk_enable_guarded: assert property (en_go && !issuer_master && !mt_wr
    |=> global_en_q == $past(global_en_q))
    else $error("global enable changed without master privilege");
  chk_overflow_cause: assert property (fork_fail
    |=> exc_code_q == tco_pkg::TCO_EXC_THREAD
        && vp_ctrl_q[$past(issuer_vp)][tco_pkg::CAUSE_LSB +: 3] == tco_pkg::CAUSE_OVERFLOW)
    else $error("overflow not reported");
  chk_fork_activates: assert property (fork_go
    |=> status_q[$past(fork_pick)][tco_pkg::ST_ACT_BIT]
        && exc_code_q == tco_pkg::TCO_EXC_NONE)
    else $error("allocated context not active");
  chk_reserved_op: assert property (go && !feat_q[tco_pkg::FEAT_MT_BIT]
    |=> exc_code_q == tco_pkg::TCO_EXC_RESERVED)
    else $error("reserved instruction not raised");
  chk_cop_unusable: assert property (go && feat_q[tco_pkg::FEAT_MT_BIT]
    && !feat_q[tco_pkg::FEAT_CP0_BIT] |=> exc_code_q == tco_pkg::TCO_EXC_COP_UNUSABLE)
    else $error("coprocessor unusable not raised");
  chk_result_pulse: assert property (res_valid_q && ce_i |=> !res_valid_q)
    else $error("result held longer than one cycle");
  chk_move_blocked: assert property (mf_go && !issuer_master && tgt_vp != issuer_vp
    |=> res_data_q == tco_pkg::ALL_ONES)
    else $error("foreign context readable without master");

  cov_fork_alloc: cover property (fork_go);
  cov_fork_overflow: cover property (fork_fail);
  cov_move_from: cover property (mf_go);
  cov_enable_master: cover property (en_go && issuer_master);
endmodule
`default_nettype wire

// >>> bench/thread_context_ops_tb_top.sv
// self-checking testbench for the thread context operations block
`timescale 1ns/100ps
`default_nettype none
module thread_context_ops_tb_top;
  logic clk_i = 0, reset_n_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rs_val_i = 0, rt_val_i = 0, prdata_o, res_data_o, q, rs, rv;
  logic e;
  int exp_st;
  logic pready_o, pslverr_o, res_valid_o, instr_valid_i = 0, u_i = 0, h_i = 0, st_we_i = 0;
  tco_pkg::tco_op_e instr_op_i = tco_pkg::TCO_OP_ENABLE_ALL;
  tco_pkg::tco_exc_e exc_code_o, exc;
  logic [1:0] issue_ctx_i = 1, st_kind_i = 0, st_ctx_i = 0;
  logic [4:0] rd_i = 0, rt_i = 0, st_idx_i = 0;
  logic [2:0] sel_i = 0;
  logic [63:0] st_data_i = 0;
  logic [3:0] ctx_run_o, ctx_addr_fault_o;
  int err_total = 0, n_checks = 0;
  tco_thread_ops tco_thread_ops_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .issue_ctx_i(issue_ctx_i),
    .rd_i(rd_i), .rt_i(rt_i), .u_i(u_i), .sel_i(sel_i), .h_i(h_i),
    .rs_val_i(rs_val_i), .rt_val_i(rt_val_i),
    .st_we_i(st_we_i), .st_kind_i(st_kind_i), .st_ctx_i(st_ctx_i), .st_idx_i(st_idx_i),
    .st_data_i(st_data_i), .res_valid_o(res_valid_o), .res_data_o(res_data_o),
    .exc_code_o(exc_code_o), .ctx_run_o(ctx_run_o), .ctx_addr_fault_o(ctx_addr_fault_o)
  );
  always #2.5 clk_i = ~clk_i;
  // ==========
  // tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i) penable_i <= 1;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    if (n >= 50) begin err_total++; stop_test(); end
    @(posedge clk_i);
  endtask
  task automatic op(input tco_pkg::tco_op_e o, input logic [31:0] v);
    int n;
    n = 0;
    instr_valid_i <= 1; instr_op_i <= o; rs_val_i <= v;
    do begin @(posedge clk_i); n++; end while (res_valid_o !== 1'b1 && n < 50);
    exc = exc_code_o;
    instr_valid_i <= 0;
    if (n >= 50) begin err_total++; stop_test(); end
    @(posedge clk_i);
  endtask
  // ==========
  // main sequence
  initial begin
    void'($urandom(4));
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1;
    @(posedge clk_i);
    apb(0, tco_pkg::ADDR_FEATURES, 0); chk("features", tco_pkg::FEAT_RESET, q);
    apb(0, tco_pkg::ADDR_STATUS, 0); chk("status", tco_pkg::STATUS_RESET, q);
    apb(0, 8'h30, 0); chk("slverr", 1, e);
    op(tco_pkg::TCO_OP_FORK, 0); chk("fork exc", tco_pkg::TCO_EXC_THREAD, exc);
    apb(0, tco_pkg::ADDR_VP_CTRL0, 0);
    chk("cause", tco_pkg::CAUSE_OVERFLOW, q[tco_pkg::CAUSE_LSB+:3]);
    $display("overflow test done");
    apb(1, tco_pkg::ADDR_FEATURES, 1);
    op(tco_pkg::TCO_OP_FORK, 0); chk("cop", tco_pkg::TCO_EXC_COP_UNUSABLE, exc);
    apb(1, tco_pkg::ADDR_FEATURES, 0);
    op(tco_pkg::TCO_OP_FORK, 0); chk("reserved", tco_pkg::TCO_EXC_RESERVED, exc);
    apb(1, tco_pkg::ADDR_FEATURES, tco_pkg::FEAT_RESET);
    $display("exception test done");
    rs = $urandom;
    rv = $urandom;
    rd_i <= 5;
    rt_val_i <= rv;
    apb(1, tco_pkg::ADDR_STATUS, 32'h1 << tco_pkg::ST_DA_BIT);
    op(tco_pkg::TCO_OP_FORK, rs); chk("fork ok", tco_pkg::TCO_EXC_NONE, exc);
    apb(0, tco_pkg::ADDR_RESTART, 0); chk("restart", rs, q);
    exp_st = (1 << tco_pkg::ST_ONE_HI_BIT) | (1 << tco_pkg::ST_DA_BIT);
    exp_st = exp_st | (1 << tco_pkg::ST_ACT_BIT);
    apb(0, tco_pkg::ADDR_STATUS, 0); chk("active", 1, q[tco_pkg::ST_ACT_BIT]);
    chk("status word", exp_st, q);
    chk("fault", rs[1] & ~rs[0], ctx_addr_fault_o[0]);
    op(tco_pkg::TCO_OP_FORK, rs); chk("refork", tco_pkg::TCO_EXC_THREAD, exc);
    $display("allocate test done");
    apb(1, 8'h48, 1);
    apb(1, tco_pkg::ADDR_VP_CTRL0, 2);
    u_i <= 1;
    rt_i <= 5;
    op(tco_pkg::TCO_OP_MOVE_FROM, 0); chk("blocked", tco_pkg::ALL_ONES, res_data_o);
    apb(1, tco_pkg::ADDR_VP_CONFIG, 1);
    apb(1, tco_pkg::ADDR_VP_CTRL0, 32'h1 << tco_pkg::THREADS_EN_BIT);
    op(tco_pkg::TCO_OP_MOVE_FROM, 0); chk("gpr", rv, res_data_o);
    u_i <= 0;
    rt_i <= 5'h13;
    op(tco_pkg::TCO_OP_MOVE_FROM, 0); chk("sysreg", rs, res_data_o);
    u_i <= 1;
    sel_i <= 7;
    op(tco_pkg::TCO_OP_MOVE_FROM, 0); chk("unimpl", tco_pkg::ALL_ONES, res_data_o);
    st_we_i <= 1;
    st_kind_i <= 1;
    st_ctx_i <= 0;
    st_idx_i <= 2;
    st_data_i <= 64'h80;
    @(posedge clk_i);
    st_kind_i <= 3;
    st_idx_i <= 3;
    st_data_i <= {rs, rv};
    @(posedge clk_i);
    st_we_i <= 0;
    sel_i <= 1;
    rt_i <= 2;
    op(tco_pkg::TCO_OP_MOVE_FROM, 0); chk("acx", 32'hffffff80, res_data_o);
    sel_i <= 2;
    rt_i <= 3;
    h_i <= 1;
    op(tco_pkg::TCO_OP_MOVE_FROM, 0); chk("high half", rs, res_data_o);
    $display("move test done");
    op(tco_pkg::TCO_OP_ENABLE_ALL, 0); chk("old enable", 0, res_data_o);
    op(tco_pkg::TCO_OP_ENABLE_ALL, 0); chk("new enable", 1, res_data_o);
    chk("run", 1, ctx_run_o[0]);
    $display("enable test done");
    stop_test();
  end
endmodule
`default_nettype wire
